/* File: iwd_field_split.sv */
// combinational split of an instruction word into category, operation and fields
`default_nettype none
`timescale 1ns/1ns
module iwd_field_split
    import iwd_pkg::*;
(
    input  wire logic [iwd_pkg::IWD_WORD_W-1:0] word,
    output iwd_pkg::iwd_dec_t                   dec
);
    wire logic [1:0] cls   = word[IWD_CLASS_HI:IWD_CLASS_LO];
    wire logic [3:0] bop   = word[IWD_BOP_HI:IWD_BOP_LO];
    wire logic [1:0] top   = word[IWD_TOP_HI:IWD_TOP_LO];
    wire logic [3:0] lop   = word[IWD_LOP_HI:IWD_LOP_LO];
    wire logic [7:0] lowb  = word[7:0];
    // x bits of the no-op pattern are masked before the compare
    wire logic [7:0] ctl   = lowb & IWD_CTL_MASK;                          // [RULE7]
    wire logic       misc  = (cls == IWD_CLS_BYTE) && (bop == IWD_BOP_MISC)
                             && !word[IWD_DEST_POS];

    iwd_op_t bop_op;
    iwd_op_t misc_op;
    iwd_op_t lit_op;
    logic    misc_bad;
    logic    lit_bad;

    always_comb begin
        unique case (bop)                                                   // [RULE10]
            4'h0: bop_op = IWD_OP_MOVWF;
            4'h1: bop_op = word[IWD_DEST_POS] ? IWD_OP_CLRF : IWD_OP_CLRW; // [RULE7]
            4'h2: bop_op = IWD_OP_SUBWF;
            4'h3: bop_op = IWD_OP_DECF;
            4'h4: bop_op = IWD_OP_IORWF;
            4'h5: bop_op = IWD_OP_ANDWF;
            4'h6: bop_op = IWD_OP_XORWF;
            4'h7: bop_op = IWD_OP_ADDWF;
            4'h8: bop_op = IWD_OP_MOVF;
            4'h9: bop_op = IWD_OP_COMF;
            4'hA: bop_op = IWD_OP_INCF;
            4'hB: bop_op = IWD_OP_DECFSZ;
            4'hC: bop_op = IWD_OP_RRF;
            4'hD: bop_op = IWD_OP_RLF;
            4'hE: bop_op = IWD_OP_SWAPF;
            4'hF: bop_op = IWD_OP_INCFSZ;
        endcase
    end

    always_comb begin
        misc_bad = 1'b0;
        misc_op  = IWD_OP_NOP;
        if (ctl == IWD_CTL_NOP) begin
            misc_op = IWD_OP_NOP;
        end else if (lowb == IWD_CTL_RETURN) begin
            misc_op = IWD_OP_RETURN;
        end else if (lowb == IWD_CTL_RETFIE || lowb == IWD_CTL_SLEEP
                     || lowb == IWD_CTL_CLRWDT) begin
            misc_op = IWD_OP_NOP;
        end else begin
            misc_bad = 1'b1;                                                // [RULE12]
        end
    end

    always_comb begin
        lit_bad = 1'b0;
        lit_op  = IWD_OP_NOP;
        if (lop[3:2] == 2'b00) begin
            lit_op = IWD_OP_MOVLW;                                          // [RULE7]
        end else if (lop[3:2] == 2'b01) begin
            lit_op = IWD_OP_RETLW;
        end else if (lop[3:1] == IWD_LOP_ADD[3:1]) begin
            lit_op = IWD_OP_ADDLW;
        end else if (lop[3:1] == IWD_LOP_SUB[3:1]) begin
            lit_op = IWD_OP_SUBLW;
        end else if (lop == IWD_LOP_IOR) begin
            lit_op = IWD_OP_IORLW;
        end else if (lop == IWD_LOP_AND) begin
            lit_op = IWD_OP_ANDLW;
        end else if (lop == IWD_LOP_XOR) begin
            lit_op = IWD_OP_XORLW;
        end else begin
            lit_bad = 1'b1;                                                 // [RULE12]
        end
    end

    always_comb begin
        dec              = '0;
        dec.file_addr    = word[IWD_FILE_W-1:0];                            // [RULE3]
        dec.bit_sel      = word[IWD_BSEL_HI:IWD_BSEL_LO];                   // [RULE5]
        unique case (cls)                                                   // [RULE2]
            IWD_CLS_BYTE: begin
                dec.cat          = IWD_CAT_BYTE;
                dec.dest_file    = word[IWD_DEST_POS];                      // [RULE4]
                dec.op           = misc ? misc_op : bop_op;
                dec.uses_file    = !misc && (bop_op != IWD_OP_CLRW);
                dec.illegal      = misc && misc_bad;
                dec.is_retfie    = misc && (lowb == IWD_CTL_RETFIE);
                dec.is_sleep     = misc && (lowb == IWD_CTL_SLEEP);
                dec.is_clrwdt    = misc && (lowb == IWD_CTL_CLRWDT);
                dec.changes_pc   = misc && (lowb == IWD_CTL_RETURN || lowb == IWD_CTL_RETFIE);
                dec.is_test      = (bop == IWD_BOP_DECFSZ) || (bop == IWD_BOP_INCFSZ);
                dec.skip_on_zero = dec.is_test;
            end
            IWD_CLS_BIT: begin                                              // [RULE11]
                dec.cat          = IWD_CAT_BIT;
                dec.uses_file    = 1'b1;
                dec.op           = iwd_op_t'(IWD_OP_BCF + 5'(top));
                dec.is_test      = top[1];
                dec.skip_on_zero = (top == IWD_TOP_SKIPCLR);
            end
            IWD_CLS_JUMP: begin
                dec.cat        = IWD_CAT_LIT;
                dec.op         = word[IWD_JUMP_POS] ? IWD_OP_GOTO : IWD_OP_CALL;
                dec.literal    = word[IWD_LIT11_W-1:0];                     // [RULE6]
                dec.lit_wide   = 1'b1;
                dec.changes_pc = 1'b1;
            end
            IWD_CLS_LIT: begin
                dec.cat        = IWD_CAT_LIT;
                dec.op         = lit_op;
                dec.literal    = {3'h0, lowb};                              // [RULE6]
                dec.illegal    = lit_bad;
                dec.changes_pc = (lit_op == IWD_OP_RETLW);
            end
        endcase
        if (dec.illegal) begin
            dec.op = IWD_OP_NOP;                                            // [RULE12]
        end
    end
endmodule
`default_nettype wire

/* File: iwd_pkg.sv */
// constants, types and operation codes of the instruction word decoder
// Behaviour
// [RULE1] each instruction is one 14-bit word, split
// [RULE2] classify byte, bit, or literal-and-control
// [RULE3] file address selects register 0x00 to 0x7F
// [RULE4] destination zero accumulator, one file register
// [RULE5] bit select picks bit of 8-bit register
// [RULE6] literal is eight or eleven bits wide
// [RULE7] don't-care bits never change decoded behaviour
// [RULE8] one cycle, two on skip or branch
// [RULE9] instruction cycle is four oscillator periods
// [RULE10] byte words: 00, op4, dest, file7
// [RULE11] bit words: 01, op2, bit3, file7
// [RULE12] undefined encodings run as one-cycle no-op
`default_nettype none
package iwd_pkg;
    localparam int IWD_WORD_W   = 14;
    localparam int IWD_FILE_W   = 7;
    localparam int IWD_BIT_W    = 3;
    localparam int IWD_LIT8_W   = 8;
    localparam int IWD_LIT11_W  = 11;
    localparam int IWD_PHASES   = 4;
    localparam logic [1:0] IWD_PHASE_LAST = 2'h3;
    localparam logic [1:0] IWD_PHASE_FIRST = 2'h0;

    // word field positions
    localparam int IWD_CLASS_HI = 13;
    localparam int IWD_CLASS_LO = 12;
    localparam int IWD_BOP_HI   = 11;
    localparam int IWD_BOP_LO   = 8;
    localparam int IWD_DEST_POS = 7;
    localparam int IWD_TOP_HI   = 11;
    localparam int IWD_TOP_LO   = 10;
    localparam int IWD_BSEL_HI  = 9;
    localparam int IWD_BSEL_LO  = 7;
    localparam int IWD_JUMP_POS = 11;
    localparam int IWD_LOP_HI   = 11;
    localparam int IWD_LOP_LO   = 8;

    localparam logic [1:0] IWD_CLS_BYTE = 2'h0;
    localparam logic [1:0] IWD_CLS_BIT  = 2'h1;
    localparam logic [1:0] IWD_CLS_JUMP = 2'h2;
    localparam logic [1:0] IWD_CLS_LIT  = 2'h3;

    // byte-oriented operation field
    localparam logic [3:0] IWD_BOP_MISC   = 4'h0;
    localparam logic [3:0] IWD_BOP_CLR    = 4'h1;
    localparam logic [3:0] IWD_BOP_DECFSZ = 4'hB;
    localparam logic [3:0] IWD_BOP_INCFSZ = 4'hF;
    // bit-oriented tests
    localparam logic [1:0] IWD_TOP_SKIPCLR = 2'h2;
    localparam logic [1:0] IWD_TOP_SKIPSET = 2'h3;
    // misc control codes in the low byte, top bit of that byte clear
    localparam logic [7:0] IWD_CTL_NOP    = 8'h00;
    localparam logic [7:0] IWD_CTL_RETURN = 8'h08;
    localparam logic [7:0] IWD_CTL_RETFIE = 8'h09;
    localparam logic [7:0] IWD_CTL_SLEEP  = 8'h63;
    localparam logic [7:0] IWD_CTL_CLRWDT = 8'h64;
    localparam logic [7:0] IWD_CTL_MASK   = 8'h9F;
    // literal operation field (bits 11:8)
    localparam logic [3:0] IWD_LOP_IOR  = 4'h8;
    localparam logic [3:0] IWD_LOP_AND  = 4'h9;
    localparam logic [3:0] IWD_LOP_XOR  = 4'hA;
    localparam logic [3:0] IWD_LOP_SUB  = 4'hC;
    localparam logic [3:0] IWD_LOP_ADD  = 4'hE;

    typedef enum logic [1:0] {
        IWD_CAT_BYTE = 2'b00,
        IWD_CAT_BIT  = 2'b01,
        IWD_CAT_LIT  = 2'b10
    } iwd_cat_t;

    typedef enum logic [4:0] {
        IWD_OP_NOP = 5'h00, IWD_OP_MOVWF = 5'h01, IWD_OP_CLRW = 5'h02,
        IWD_OP_CLRF = 5'h03, IWD_OP_SUBWF = 5'h04, IWD_OP_DECF = 5'h05,
        IWD_OP_IORWF = 5'h06, IWD_OP_ANDWF = 5'h07, IWD_OP_XORWF = 5'h08,
        IWD_OP_ADDWF = 5'h09, IWD_OP_MOVF = 5'h0A, IWD_OP_COMF = 5'h0B,
        IWD_OP_INCF = 5'h0C, IWD_OP_DECFSZ = 5'h0D, IWD_OP_RRF = 5'h0E,
        IWD_OP_RLF = 5'h0F, IWD_OP_SWAPF = 5'h10, IWD_OP_INCFSZ = 5'h11,
        IWD_OP_BCF = 5'h12, IWD_OP_BSF = 5'h13, IWD_OP_BTFSC = 5'h14,
        IWD_OP_BTFSS = 5'h15, IWD_OP_CALL = 5'h16, IWD_OP_GOTO = 5'h17,
        IWD_OP_MOVLW = 5'h18, IWD_OP_RETLW = 5'h19, IWD_OP_IORLW = 5'h1A,
        IWD_OP_ANDLW = 5'h1B, IWD_OP_XORLW = 5'h1C, IWD_OP_SUBLW = 5'h1D,
        IWD_OP_ADDLW = 5'h1E, IWD_OP_RETURN = 5'h1F
    } iwd_op_t;

    typedef struct packed {
        iwd_cat_t               cat;
        iwd_op_t                op;
        logic [IWD_FILE_W-1:0]  file_addr;
        logic                   dest_file;
        logic [IWD_BIT_W-1:0]   bit_sel;
        logic [IWD_LIT11_W-1:0] literal;
        logic                   lit_wide;
        logic                   uses_file;
        logic                   is_retfie;
        logic                   is_sleep;
        logic                   is_clrwdt;
        logic                   changes_pc;
        logic                   is_test;
        logic                   skip_on_zero;
        logic                   illegal;
    } iwd_dec_t;
endpackage
`default_nettype wire

/* File: iwd_decoder.sv */
// instruction word decoder top with four-phase instruction cycle sequencing
`default_nettype none
`timescale 1ns/1ns
module iwd_decoder
    import iwd_pkg::*;
(
    input  wire logic                           sys_clk,
    input  wire logic                           reset_n,
    input  wire logic [iwd_pkg::IWD_WORD_W-1:0] instr_word,
    input  wire logic                           test_zero,
    input  wire logic                           test_bit,
    output iwd_pkg::iwd_dec_t                   dec_out,
    output logic [1:0]                          phase_out,
    output logic                                cycle_start,
    output logic                                flush_cycle,
    output logic                                word_take
);
    // -----------------------------------------------------------------
    // decode
    // -----------------------------------------------------------------
    iwd_dec_t dec_w;

    iwd_field_split u_split (
        .word (instr_word),                                                 // [RULE1]
        .dec  (dec_w)
    );

    // -----------------------------------------------------------------
    // phase counter: four clocks make one instruction cycle
    // -----------------------------------------------------------------
    logic [1:0] phase_q;
    logic       flush_q;
    wire logic [1:0] phase_d   = phase_q + 2'h1;                            // [RULE9]
    wire logic       last_ph   = (phase_q == IWD_PHASE_LAST);

    // skip taken when the test outcome matches; a branch always takes two cycles
    wire logic skip_hit = dec_out.is_test &&
                          (dec_out.cat == IWD_CAT_BIT ?
                           (test_bit == !dec_out.skip_on_zero) : test_zero);
    wire logic two_cyc  = !flush_q && (dec_out.changes_pc || skip_hit);    // [RULE8]

    wire logic flush_d = last_ph ? two_cyc : flush_q;
    wire logic take_d  = (phase_d == IWD_PHASE_LAST);

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            phase_q <= IWD_PHASE_FIRST;
            flush_q <= 1'b0;
        end else begin
            phase_q <= phase_d;                                             // [RULE9]
            flush_q <= flush_d;                                             // [RULE8]
        end
    end

    // -----------------------------------------------------------------
    // outputs: dec_out and flush_cycle latched at the instruction cycle boundary, phase_out, cycle_start and word_take every clock
    // -----------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            dec_out     <= '0;
            phase_out   <= IWD_PHASE_FIRST;
            cycle_start <= 1'b0;
            flush_cycle <= 1'b0;
            word_take   <= 1'b0;
        end else begin
            phase_out   <= phase_d;
            cycle_start <= last_ph;
            word_take   <= take_d;
            if (last_ph) begin
                // second cycle of a two-cycle op is a no-op
                dec_out     <= two_cyc ? iwd_dec_t'('0) : dec_w;            // [RULE8]
                flush_cycle <= two_cyc;
            end
        end
    end
endmodule
`default_nettype wire

/* File: iwd_decoder_assertions.sv */
// concurrent checks on the ports of the instruction word decoder
`default_nettype none
`timescale 1ns/1ns
module iwd_decoder_assertions
    import iwd_pkg::*;
(
    input wire logic                           sys_clk,
    input wire logic                           reset_n,
    input wire logic [iwd_pkg::IWD_WORD_W-1:0] instr_word,
    input wire logic                           test_zero,
    input wire logic                           test_bit,
    input wire iwd_pkg::iwd_dec_t              dec_out,
    input wire logic [1:0]                     phase_out,
    input wire logic                           cycle_start,
    input wire logic                           flush_cycle,
    input wire logic                           word_take
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    // ----------------------------------------
    // cycle timing
    // ----------------------------------------
    sequence s_cycle_gap;
        !cycle_start [*3] ##1 cycle_start;
    endsequence
    sequence s_new_cycle(logic fl);
        ##4 (cycle_start && flush_cycle == fl);
    endsequence
    wire logic fresh_c = cycle_start && !flush_cycle;
    // the first edge after reset release still sees the reset phase
    chk_phase_step: assert property ($past(reset_n) |->
        phase_out == $past(phase_out) + 2'h1) else $error("phase did not advance by one");
    chk_start_phase: assert property ($past(reset_n) && (phase_out == 2'h0) |->
        cycle_start) else $error("cycle start missing in phase zero");
    chk_take_start: assert property (word_take |-> phase_out == 2'h3 ##1 cycle_start)
        else $error("word take not followed by cycle start");
    chk_start_gap: assert property (cycle_start |=> s_cycle_gap)
        else $error("instruction cycle not four clocks");
    chk_dec_hold: assert property (!cycle_start |-> $stable(dec_out))
        else $error("decoded word changed inside a cycle");
    // ----------------------------------------
    // operand fields
    // ----------------------------------------
    chk_file_field: assert property (fresh_c && dec_out.uses_file |->
        dec_out.file_addr == $past(instr_word[6:0])) else $error("file address wrong");
    chk_dest_field: assert property (fresh_c && dec_out.uses_file &&
        dec_out.cat == IWD_CAT_BYTE |-> dec_out.dest_file == $past(instr_word[7]))
        else $error("destination select wrong");
    chk_bit_field: assert property (fresh_c && dec_out.cat == IWD_CAT_BIT |->
        dec_out.bit_sel == $past(instr_word[9:7])) else $error("bit select wrong");
    chk_lit_short: assert property (fresh_c && $past(instr_word[13:12]) == 2'h3 |->
        dec_out.literal == {3'h0, $past(instr_word[7:0])}) else $error("short literal wrong");
    chk_lit_wide: assert property (fresh_c && $past(instr_word[13:12]) == 2'h2 |->
        dec_out.lit_wide && dec_out.literal == $past(instr_word[10:0]))
        else $error("wide literal wrong");
    // ----------------------------------------
    // two-cycle execution
    // ----------------------------------------
    chk_jump_flush: assert property (fresh_c && dec_out.changes_pc |-> s_new_cycle(1'b1))
        else $error("jump not followed by flushed cycle");
    chk_flush_once: assert property (cycle_start && flush_cycle |->
        dec_out == '0 ##0 s_new_cycle(1'b0)) else $error("flushed cycle extended");
    chk_illegal_nop: assert property (cycle_start && dec_out.illegal |->
        dec_out.op == IWD_OP_NOP ##0 s_new_cycle(1'b0)) else $error("undefined word not nop");
endmodule
`default_nettype wire

/* File: iwd_fetch_model.sv */
// program fetch side: presents a word and test results while the decoder takes them
`default_nettype none
`timescale 1ns/1ns
module iwd_fetch_model
    import iwd_pkg::*;
(
    input  wire logic                           word_take,
    input  wire logic [iwd_pkg::IWD_WORD_W-1:0] load_word,
    input  wire logic                           load_zero,
    input  wire logic                           load_bit,
    output logic      [iwd_pkg::IWD_WORD_W-1:0] instr_word,
    output logic                                test_zero,
    output logic                                test_bit
);
    // outside the take window the lines show the inverse, never a stale value
    assign instr_word = word_take ? load_word : ~load_word;
    assign test_zero  = word_take ? load_zero : ~load_zero;
    assign test_bit   = word_take ? load_bit  : ~load_bit;
endmodule
`default_nettype wire

/* File: iwd_decoder_tb_top.sv */
// self-checking testbench of the instruction word decoder
`default_nettype none
`timescale 1ns/1ns
module iwd_decoder_tb_top;
    import iwd_pkg::*;
    logic                  sys_clk, reset_n, load_zero, load_bit;
    logic [IWD_WORD_W-1:0] load_word, instr_word;
    logic                  test_zero, test_bit, cycle_start, flush_cycle, word_take;
    iwd_dec_t              dec_out;
    logic [1:0]            phase_out;
    int                    err_total, comparisons;
    iwd_decoder iwd_decoder_i (.sys_clk, .reset_n, .instr_word, .test_zero, .test_bit,
        .dec_out, .phase_out, .cycle_start, .flush_cycle, .word_take);
    iwd_fetch_model iwd_fetch_model_i (.word_take, .load_word, .load_zero, .load_bit,
        .instr_word, .test_zero, .test_bit);
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    task ck(string n, logic [15:0] s, logic [15:0] e);
        comparisons++;
        if (s !== e) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    // hands over w plus the test results of the running instruction
    task issue(logic [13:0] w, logic tz, logic tb);
        int n;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (phase_out !== 2'h2 && n < 8);
        load_word <= w;
        load_zero <= tz;
        load_bit  <= tb;
        @(posedge sys_clk);
        #1;
    endtask
    task t_byte;
        issue(14'h07FF, 1'b0, 1'b0);
        ck("cat", dec_out.cat, IWD_CAT_BYTE);
        ck("op", dec_out.op, IWD_OP_ADDWF);
        ck("file", dec_out.file_addr, 16'h007F);
        ck("dest", dec_out.dest_file, 16'h0001);
        issue(14'h0700, 1'b0, 1'b0);
        ck("file", dec_out.file_addr, 16'h0000);
        ck("dest", dec_out.dest_file, 16'h0000);
    endtask
    task t_bit;
        issue(14'h17D5, 1'b0, 1'b0);
        ck("cat", dec_out.cat, IWD_CAT_BIT);
        ck("op", dec_out.op, IWD_OP_BSF);
        ck("bit", dec_out.bit_sel, 16'h0007);
        ck("file", dec_out.file_addr, 16'h0055);
    endtask
    task t_literal;
        issue(14'h33A5, 1'b0, 1'b0);
        ck("cat", dec_out.cat, IWD_CAT_LIT);
        ck("lit", dec_out.literal, 16'h00A5);
        issue(14'h30A5, 1'b0, 1'b0);
        ck("op", dec_out.op, IWD_OP_MOVLW);
        ck("lit", dec_out.literal, 16'h00A5);
        issue(14'h2FFF, 1'b0, 1'b0);
        ck("op", dec_out.op, IWD_OP_GOTO);
        ck("lit", {dec_out.lit_wide, dec_out.literal}, 16'h0FFF);
        issue(14'h3E12, 1'b0, 1'b0);
        ck("flush", {flush_cycle, dec_out == '0}, 16'h0003);
        issue(14'h3E12, 1'b0, 1'b0);
        ck("op", {flush_cycle, 3'h0, dec_out.op}, IWD_OP_ADDLW);
    endtask
    task t_skip;
        issue(14'h0B80, 1'b0, 1'b0);
        issue(14'h0100, 1'b1, 1'b0);
        ck("flush", flush_cycle, 16'h0001);
        issue(14'h0B80, 1'b0, 1'b0);
        issue(14'h0100, 1'b0, 1'b0);
        ck("op", {flush_cycle, 3'h0, dec_out.op}, IWD_OP_CLRW);
        issue(14'h1800, 1'b0, 1'b0);
        issue(14'h1C00, 1'b1, 1'b0);
        ck("flush", flush_cycle, 16'h0001);
        issue(14'h1C00, 1'b1, 1'b0);
        issue(14'h1C00, 1'b0, 1'b1);
        ck("flush", flush_cycle, 16'h0001);
    endtask
    task t_illegal;
        issue(14'h0001, 1'b0, 1'b0);
        ck("illegal", {dec_out.illegal, 3'h0, dec_out.op}, 16'h0100);
        issue(14'h0000, 1'b1, 1'b1);
        ck("flush", flush_cycle, 16'h0000);
    endtask
    task t_control;
        issue(14'h0060, 1'b0, 1'b0);
        ck("nopx", {dec_out.illegal, 3'h0, dec_out.op}, 16'h0000);
        issue(14'h0008, 1'b0, 1'b0);
        ck("ret", {dec_out.changes_pc, 3'h0, dec_out.op}, {8'h01, 3'h0, IWD_OP_RETURN});
        issue(14'h0063, 1'b0, 1'b0);
        ck("flush", {flush_cycle, dec_out == '0}, 16'h0003);
        issue(14'h0063, 1'b0, 1'b0);
        ck("sleep", {dec_out.is_sleep, 3'h0, dec_out.op}, 16'h0100);
        issue(14'h3B00, 1'b0, 1'b0);
        ck("illegal", {dec_out.illegal, 3'h0, dec_out.op}, 16'h0100);
        issue(14'h3400, 1'b0, 1'b0);
        ck("retlw", {dec_out.changes_pc, 3'h0, dec_out.op}, {8'h01, 3'h0, IWD_OP_RETLW});
        issue(14'h2000, 1'b0, 1'b0);
        ck("flush", flush_cycle, 16'h0001);
        issue(14'h2000, 1'b0, 1'b0);
        ck("call", {dec_out.lit_wide, 3'h0, dec_out.op}, {8'h01, 3'h0, IWD_OP_CALL});
        issue(14'h1800, 1'b0, 1'b0);
        ck("flush", flush_cycle, 16'h0001);
        issue(14'h1800, 1'b0, 1'b0);
        issue(14'h017F, 1'b0, 1'b1);
        ck("clrw", {flush_cycle, 3'h0, dec_out.op}, IWD_OP_CLRW);
    endtask
    task final_report;
        $display("mismatches %0d comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        #20000;
        err_total++;
        final_report();
    end
    initial begin
        reset_n = 1'b0;
        {load_word, load_zero, load_bit} = '0;
        repeat (10) @(posedge sys_clk);
        reset_n <= 1'b1;
        t_byte();
        t_bit();
        t_literal();
        t_skip();
        t_illegal();
        t_control();
        final_report();
    end
endmodule
bind iwd_decoder iwd_decoder_assertions iwd_decoder_assertions_i (.sys_clk, .reset_n,
    .instr_word, .test_zero, .test_bit, .dec_out, .phase_out, .cycle_start, .flush_cycle,
    .word_take);
`default_nettype wire
